// File: rtl/sosc_config_bank.sv
// operation and trigger configuration bank with conversion sequencer
// assumes the serial engine presents decoded register accesses as
// one-cycle strobes, and the analog front end follows conv_start
`timescale 1ns/1ns
module sosc_config_bank
  import sosc_pkg::*;
#(
  parameter int MS_CYC      = MS_CYCLES,
  parameter int CONV_CYC_DIV = 1
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       cmd_trigger,
  input  wire logic       int_trigger_n,
  input  wire logic       multi_axis,
  input  wire logic [3:0] idle_interval_select,
  input  wire logic       wake_exit,
  input  wire logic [7:0] axis_threshold_value,
  output logic            crc_append,
  output logic            rd_frame_standard,
  output logic            rd_frame_word,
  output logic            rd_frame_byte,
  output logic            glitch_filter_on,
  output logic            sleep_active,
  output logic            idle_low_power,
  output logic            conv_start,
  output logic            conv_busy,
  output logic            conv_done,
  output logic      [5:0] active_avg_samples,
  output logic            active_tempco_ndfeb,
  output logic            active_tempco_ceramic,
  output logic            active_low_noise,
  output logic      [7:0] thr_upper,
  output logic      [7:0] thr_lower,
  output logic            thr_pair_mode
);

  // ==========================================================
  // helpers
  function automatic logic [5:0] avg_samples(input logic [2:0] c);
    logic [5:0] n;
    case (c)
      3'h0:    n = 6'h01;
      3'h1:    n = 6'h02;
      3'h2:    n = 6'h04;
      3'h3:    n = 6'h08;
      3'h4:    n = 6'h10;
      default: n = 6'h20;
    endcase
    return n;
  endfunction

  function automatic logic [17:0] conv_len(input logic [2:0] c,
                                           input logic       m);
    int n;
    n = conv_ns(c, m) / CLK_PERIOD_NS / CONV_CYC_DIV;
    if (n < 1) begin
      n = 1;
    end
    return 18'(n);
  endfunction

  // ==========================================================
  // registers
  logic [7:0]  conv_if_reg;
  logic [7:0]  op_trig_reg;
  logic [7:0]  rdata_reg;
  logic [2:0]  pin_sync_reg;
  logic        pin_level_reg;
  logic        trig_pend_reg;
  sosc_seq_t   seq_reg;
  sosc_seq_t   seq_next;
  logic [17:0] cnt_reg;
  logic        start_reg;
  logic        done_reg;
  logic [5:0]  avg_reg;
  logic        tc_nd_reg;
  logic        tc_ce_reg;
  logic        ln_reg;
  logic [7:0]  thr_up_reg;
  logic [7:0]  thr_lo_reg;
  logic        pair_reg;
  logic [3:0]  idle_code_reg;

  // ==========================================================
  // field decode
  wire       hit_conv = reg_addr == OFF_CONV_IF;
  wire       hit_op   = reg_addr == OFF_OP_TRIG;
  wire [1:0] tempco   = conv_if_reg[TEMPCO_LSB +: 2];
  wire [2:0] avg_code = conv_if_reg[AVG_LSB +: 3];
  wire [1:0] rd_frame = conv_if_reg[RDF_LSB +: 2];
  wire [2:0] thr_mode = op_trig_reg[THR_LSB +: 3];
  wire       low_nz   = op_trig_reg[LN_BIT];
  wire       trig_pin = op_trig_reg[TRIG_BIT];
  wire [1:0] op_state = op_trig_reg[OPS_LSB +: 2];
  wire       standby  = op_state == OPS_STANDBY;  // RULE14
  wire       cont     = op_state == OPS_CONT;     // RULE14
  wire       wake     = op_state == OPS_WAKE;     // RULE14
  wire       to_stby  = wake && wake_exit;        // RULE15

  // ==========================================================
  // trigger source
  wire pin_agree = pin_sync_reg[2] == pin_sync_reg[1];
  wire pin_fall  = pin_level_reg && pin_agree && !pin_sync_reg[2];
  wire trig_evt  = trig_pin ? pin_fall : cmd_trigger;  // RULE11
  wire trig_std  = standby && trig_evt;                // RULE13

  // ==========================================================
  // sequencer decode
  wire conv_end = (seq_reg == SEQ_CONV) && (cnt_reg == 18'h00000);
  wire timer_done;
  wire timer_busy;
  wire go_std   = standby && (trig_std || trig_pend_reg);  // RULE12
  wire go       = (seq_reg == SEQ_IDLE) && (go_std || cont || wake);
  wire wait_go  = conv_end && wake && !to_stby;             // RULE16
  wire timer_abort = (seq_reg == SEQ_WAIT) && (!wake || to_stby);

  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        if (go) begin
          seq_next = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (conv_end) begin
          seq_next = wait_go ? SEQ_WAIT : SEQ_IDLE;
        end
      end
      SEQ_WAIT: begin
        if (!wake || to_stby || timer_done) begin
          seq_next = SEQ_IDLE;  // RULE16
        end
      end
      default: seq_next = SEQ_IDLE;
    endcase
  end

  // ==========================================================
  // threshold interpretation
  wire [6:0] mag     = axis_threshold_value[6:0];
  wire       pair    = thr_mode == THR_PAIR;                 // RULE8
  wire [7:0] up_next = pair ? {1'b0, mag}                    // RULE8
                            : axis_threshold_value;          // RULE7
  wire [7:0] lo_next = pair ? 8'(-{1'b0, mag})               // RULE8
                            : axis_threshold_value;          // RULE7

  // ==========================================================
  // read data
  wire [7:0] rd_mux = hit_conv ? conv_if_reg
                    : hit_op   ? op_trig_reg
                    : 8'h00;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_if_reg <= RST_CONV_IF;  // RULE17
      op_trig_reg <= RST_OP_TRIG;  // RULE17
    end else begin
      if (reg_wr && hit_conv) begin
        conv_if_reg <= reg_wdata;  // RULE17
      end
      if (to_stby) begin
        op_trig_reg[OPS_LSB +: 2] <= OPS_STANDBY;  // RULE15
        if (reg_wr && hit_op) begin
          op_trig_reg[7:2] <= reg_wdata[7:2];
        end
      end else if (reg_wr && hit_op) begin
        op_trig_reg <= reg_wdata;  // RULE17
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;  // RULE17
    end
  end

  // ==========================================================
  // interrupt pin synchroniser, idles high; a level counts once
  // the second and third stages agree, so a runt cannot trigger
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync_reg  <= 3'h7;
      pin_level_reg <= 1'b1;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], int_trigger_n};
      if (pin_agree) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  // ==========================================================
  // pending trigger: one held, the rest dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trig_pend_reg <= 1'b0;
    end else if (!standby || go) begin
      trig_pend_reg <= 1'b0;  // RULE13
    end else if (trig_std) begin
      trig_pend_reg <= 1'b1;  // RULE12
    end
  end

  // ==========================================================
  // conversion sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_reg   <= SEQ_IDLE;
      cnt_reg   <= 18'h00000;
      start_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      seq_reg   <= seq_next;
      start_reg <= go;
      done_reg  <= conv_end;
      if (go) begin
        cnt_reg <= conv_len(avg_code, multi_axis) - 18'h00001;  // RULE4
      end else if (seq_reg == SEQ_CONV && !conv_end) begin
        cnt_reg <= cnt_reg - 18'h00001;
      end
    end
  end

  // ==========================================================
  // settings taken at each conversion start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avg_reg    <= 6'h01;
      tc_nd_reg  <= 1'b0;
      tc_ce_reg  <= 1'b0;
      ln_reg     <= 1'b0;
      thr_up_reg <= 8'h00;
      thr_lo_reg <= 8'h00;
      pair_reg   <= 1'b0;
    end else if (go) begin
      avg_reg    <= avg_samples(avg_code);   // RULE3
      tc_nd_reg  <= tempco == TC_NDFEB;      // RULE2
      tc_ce_reg  <= tempco == TC_CERAMIC;    // RULE2
      ln_reg     <= low_nz;                  // RULE9
      thr_up_reg <= up_next;
      thr_lo_reg <= lo_next;
      pair_reg   <= pair;
    end
  end

  // ==========================================================
  // idle interval code held for the whole interval, so that a host
  // write in mid-interval can neither cut nor stretch the count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_code_reg <= 4'h0;
    end else if (wait_go) begin
      idle_code_reg <= idle_interval_select;  // RULE16
    end
  end

  // ==========================================================
  // idle interval between wake-and-sleep conversions
  sosc_idle_timer #(
    .MS_CYC (MS_CYC)
  ) u_idle (
    .clock (clock),
    .rst   (rst),
    .start (wait_go),
    .abort (timer_abort),
    .code  (idle_code_reg),
    .busy  (timer_busy),
    .done  (timer_done)
  );

  // ==========================================================
  // outputs
  assign reg_rdata             = rdata_reg;
  assign crc_append            = conv_if_reg[CRC_BIT];         // RULE1
  assign rd_frame_standard     = rd_frame == RDF_STD ||
                                 rd_frame == 2'h3;             // RULE5
  assign rd_frame_word         = rd_frame == RDF_WORD;         // RULE6
  assign rd_frame_byte         = rd_frame == RDF_BYTE;         // RULE6
  assign glitch_filter_on      = !op_trig_reg[GLF_BIT];        // RULE10
  assign sleep_active          = op_state == OPS_SLEEP;        // RULE14
  assign idle_low_power        = timer_busy;                   // RULE16
  assign conv_start            = start_reg;
  assign conv_busy             = seq_reg == SEQ_CONV;
  assign conv_done             = done_reg;
  assign active_avg_samples    = avg_reg;
  assign active_tempco_ndfeb   = tc_nd_reg;
  assign active_tempco_ceramic = tc_ce_reg;
  assign active_low_noise      = ln_reg;
  assign thr_upper             = thr_up_reg;
  assign thr_lower             = thr_lo_reg;
  assign thr_pair_mode         = pair_reg;

endmodule

// File: rtl/sosc_pkg.sv
// package of the operation and trigger configuration bank
// assumes a 100 MHz core clock and an 8-bit internal register port
//
// How it works
// RULE1: the top bit of the first register turns the read checksum on.
// RULE2: magnet tempco code 0 is none, 1 is 0.12 %/C, 2 reserved, 3 0.2 %/C.
// RULE3: averaging codes 0 to 5 select 1, 2, 4, 8, 16 and 32 samples.
// RULE4: single-sample conversions run at 10 kSPS on three axes, 20 kSPS on one.
// RULE5: read-frame code 0 serves the standard three-byte read command.
// RULE6: frame code 1 is a 16-bit short read, 2 an 8-bit short read, 3 reserved.
// RULE7: threshold code 0 takes the axis threshold as one signed threshold.
// RULE8: threshold code 1 takes seven low bits as a +/- magnitude pair.
// RULE9: bit 4 of the second register picks low noise over low current.
// RULE10: bit 3 of the second register bypasses the serial spike filter.
// RULE11: bit 2 picks the interrupt pin over serial command bits as start.
// RULE12: a trigger during a conversion waits for its end; extras are dropped.
// RULE13: the start source acts only in standby, one conversion per trigger.
// RULE14: operating state 0 standby, 1 sleep, 2 continuous, 3 wake-and-sleep.
// RULE15: leaving wake-and-sleep for standby rewrites the state field.
// RULE16: wake-and-sleep idles for the selected interval, 1 ms at code 0.
// RULE17: both registers reset to zero and read back; conversion fields apply at next start, the rest at once.
package sosc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CONV_IF  = 8'h00;
  localparam logic [7:0] OFF_OP_TRIG  = 8'h01;
  localparam logic [7:0] RST_CONV_IF  = 8'h00;
  localparam logic [7:0] RST_OP_TRIG  = 8'h00;

  // ==========================================================
  // field positions
  localparam int CRC_BIT    = 7;
  localparam int TEMPCO_LSB = 5;
  localparam int AVG_LSB    = 2;
  localparam int RDF_LSB    = 0;
  localparam int THR_LSB    = 5;
  localparam int LN_BIT     = 4;
  localparam int GLF_BIT    = 3;
  localparam int TRIG_BIT   = 2;
  localparam int OPS_LSB    = 0;

  // ==========================================================
  // codes
  localparam logic [1:0] OPS_STANDBY = 2'h0;
  localparam logic [1:0] OPS_SLEEP   = 2'h1;
  localparam logic [1:0] OPS_CONT    = 2'h2;
  localparam logic [1:0] OPS_WAKE    = 2'h3;
  localparam logic [1:0] RDF_STD     = 2'h0;
  localparam logic [1:0] RDF_WORD    = 2'h1;
  localparam logic [1:0] RDF_BYTE    = 2'h2;
  localparam logic [1:0] TC_NDFEB    = 2'h1;
  localparam logic [1:0] TC_CERAMIC  = 2'h3;
  localparam logic [2:0] THR_SIGNED  = 3'h0;
  localparam logic [2:0] THR_PAIR    = 3'h1;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_WAIT} sosc_seq_t;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES   = 3;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // conversion time per averaging code, ns, rounded down
  function automatic int conv_ns(input logic [2:0] avg,
                                 input logic       multi);
    int t;
    case (avg)
      3'h0:    t = multi ? 100000  : 50000;
      3'h1:    t = multi ? 175438  : 75187;
      3'h2:    t = multi ? 322580  : 125000;
      3'h3:    t = multi ? 625000  : 227272;
      3'h4:    t = multi ? 1250000 : 416666;
      default: t = multi ? 2500000 : 833333;
    endcase
    return t;
  endfunction

  // idle interval in ms; reserved codes take the longest
  function automatic logic [14:0] idle_ms(input logic [3:0] code);
    logic [14:0] m;
    case (code)
      4'h0:    m = 15'h0001;
      4'h1:    m = 15'h0005;
      4'h2:    m = 15'h000A;
      4'h3:    m = 15'h000F;
      4'h4:    m = 15'h0014;
      4'h5:    m = 15'h001E;
      4'h6:    m = 15'h0032;
      4'h7:    m = 15'h0064;
      4'h8:    m = 15'h01F4;
      4'h9:    m = 15'h03E8;
      4'hA:    m = 15'h07D0;
      4'hB:    m = 15'h1388;
      default: m = 15'h4E20;
    endcase
    return m;
  endfunction

endpackage

// File: rtl/sosc_idle_timer.sv
// idle interval timer for wake-and-sleep operation
// assumes a one-cycle start pulse and a stable interval code while busy
`timescale 1ns/1ns
module sosc_idle_timer
  import sosc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [3:0] code,
  output logic            busy,
  output logic            done
);

  logic [16:0] div_reg;
  logic [14:0] ms_reg;
  logic        busy_reg;
  logic        done_reg;
  wire         ms_tick = busy_reg && (div_reg == 17'(MS_CYC - 1));
  wire         last_ms = ms_tick && (ms_reg == idle_ms(code) - 15'h0001);

  // ==========================================================
  // millisecond enable and interval count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg  <= 17'h00000;
      ms_reg   <= 15'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= last_ms && !abort;
      if (start || abort || !busy_reg || ms_tick) begin
        div_reg <= 17'h00000;
      end else begin
        div_reg <= div_reg + 17'h00001;
      end
      if (start) begin
        ms_reg   <= 15'h0000;
        busy_reg <= 1'b1;
      end else if (abort || last_ms) begin
        busy_reg <= 1'b0;
      end else if (ms_tick) begin
        ms_reg <= ms_reg + 15'h0001;
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule

// File: bench/sosc_host_model.sv
// host model: serial engine register strobes and conversion triggers
// assumes one calling process; all drives land on the falling edge
`timescale 1ns/1ns
module sosc_host_model
  import sosc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            cmd_trigger,
  output logic            int_trigger_n
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    cmd_trigger = 1'b0;
    int_trigger_n = 1'b1;
  end
  // ==========================================================
  // register accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    // released data no longer shows the written byte
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // ==========================================================
  // triggers
  task automatic trig();
    @(negedge clock);
    cmd_trigger = 1'b1;
    @(negedge clock);
    cmd_trigger = 1'b0;
  endtask
  task automatic pin(input logic v);
    @(negedge clock);
    int_trigger_n = v;
  endtask
endmodule

// File: bench/sosc_config_bank_assertions.sv
// port checker for the configuration bank
// assumes it is bound to the top module by name
`timescale 1ns/1ns
module sosc_config_bank_assertions
  import sosc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       wake_exit,
  input wire logic       crc_append,
  input wire logic       rd_frame_standard,
  input wire logic       rd_frame_word,
  input wire logic       glitch_filter_on,
  input wire logic       sleep_active,
  input wire logic       conv_start,
  input wire logic       conv_busy,
  input wire logic       conv_done,
  input wire logic [5:0] active_avg_samples,
  input wire logic       active_tempco_ndfeb,
  input wire logic       active_tempco_ceramic,
  input wire logic [7:0] thr_upper,
  input wire logic [7:0] thr_lower,
  input wire logic       thr_pair_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic wr0 = reg_wr && reg_addr == OFF_CONV_IF;
  wire logic wr1 = reg_wr && reg_addr == OFF_OP_TRIG && !wake_exit;
  // ==========================================================
  // register fields
  a_crc_bit: assert property (
    wr0 |=> crc_append == $past(reg_wdata[CRC_BIT]))
    else $error("crc flag not taken from write");
  a_frame_word: assert property (
    wr0 |=> rd_frame_word == ($past(reg_wdata[1:0]) == RDF_WORD))
    else $error("word frame flag wrong");
  a_frame_std: assert property (
    wr0 |=> rd_frame_standard == ($past(reg_wdata[1:0]) != RDF_WORD
      && $past(reg_wdata[1:0]) != RDF_BYTE))
    else $error("standard frame flag wrong");
  a_filter_bit: assert property (
    wr1 |=> glitch_filter_on == !$past(reg_wdata[GLF_BIT]))
    else $error("filter flag wrong");
  a_sleep_code: assert property (
    wr1 |=> sleep_active == ($past(reg_wdata[1:0]) == OPS_SLEEP))
    else $error("sleep flag wrong");
  a_tempco_excl: assert property (
    !(active_tempco_ndfeb && active_tempco_ceramic))
    else $error("two tempco selections");
  // ==========================================================
  // conversion sequencing
  a_start_busy: assert property (
    conv_start |-> conv_busy)
    else $error("start without busy");
  a_done_ends: assert property (
    $fell(conv_busy) |-> conv_done)
    else $error("busy ended without done");
  a_one_start: assert property (
    $past(conv_busy) && conv_busy |-> !conv_start)
    else $error("start inside a conversion");
  a_avg_onehot: assert property (
    conv_start |-> $onehot(active_avg_samples))
    else $error("sample count not a power of two");
  a_thr_pair: assert property (
    thr_pair_mode |-> thr_lower == 8'h00 - thr_upper)
    else $error("pair thresholds not opposite");
endmodule

// File: bench/sosc_config_bank_tb.sv
// self-checking bench of the configuration bank
// assumes the host model drives strobes; short counts by parameter
`timescale 1ns/1ns
module sosc_config_bank_tb;
  import sosc_pkg::*;
  logic       clock, rst, multi_axis, wake_exit, reg_wr, reg_rd;
  logic       cmd_trigger, int_trigger_n, crc_append, glitch_filter_on;
  logic       rd_frame_standard, rd_frame_word, rd_frame_byte;
  logic       sleep_active, idle_low_power, conv_start, conv_busy;
  logic       conv_done, active_tempco_ndfeb, active_tempco_ceramic;
  logic       active_low_noise, thr_pair_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, axis_threshold_value;
  logic [7:0] thr_upper, thr_lower, d, v, u;
  logic [5:0] active_avg_samples;
  logic [3:0] idle_interval_select;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         starts = 0;
  int         k, n0;
  sosc_config_bank #(.MS_CYC(20), .CONV_CYC_DIV(500))
    sosc_config_bank_i (.*);
  sosc_host_model sosc_host_model_i (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (conv_start === 1'b1) starts <= starts + 1;
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    sosc_host_model_i.rd(a, d);
    chk(d, e);
  endtask
  task automatic wait_start();
    k = 0;
    while (conv_start !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
  endtask
  task automatic wait_done();
    k = 0;
    while (conv_done !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    multi_axis = 1'b0;
    wake_exit = 1'b0;
    idle_interval_select = 4'h0;
    axis_threshold_value = 8'h00;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    rdc(OFF_CONV_IF, RST_CONV_IF);
    rdc(OFF_OP_TRIG, RST_OP_TRIG);
    chk({crc_append, rd_frame_standard, glitch_filter_on}, 8'h03);
    sosc_host_model_i.wr(8'h02, 8'h5A);
    rdc(8'h02, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = {i[0], 5'h00, i[1:0]};
      sosc_host_model_i.wr(OFF_CONV_IF, v);
      rdc(OFF_CONV_IF, v);
      chk(crc_append, i[0]);
      chk({rd_frame_standard, rd_frame_word, rd_frame_byte},
          {i == 0 || i == 3, i == 1, i == 2});
    end
    sosc_host_model_i.wr(OFF_OP_TRIG, 8'h08);
    chk(glitch_filter_on, 1'b0);
    for (int i = 0; i < 6; i++) begin
      axis_threshold_value = 8'h83 + i[7:0];
      sosc_host_model_i.wr(OFF_CONV_IF, {1'b0, i[1:0], i[2:0], 2'b00});
      sosc_host_model_i.wr(OFF_OP_TRIG, {2'b00, i[0], i[0], 4'h0});
      sosc_host_model_i.trig();
      wait_start();
      u = i[0] ? {1'b0, axis_threshold_value[6:0]} : axis_threshold_value;
      chk(active_avg_samples, 8'h01 << i);
      chk({active_tempco_ndfeb, active_tempco_ceramic},
          {i[1:0] == 2'h1, i[1:0] == 2'h3});
      chk(active_low_noise, i[0]);
      chk(thr_upper, u);
      chk(thr_lower, i[0] ? 8'h00 - u : u);
      wait_done();
    end
    sosc_host_model_i.wr(OFF_CONV_IF, 8'h00);
    for (int i = 0; i < 2; i++) begin
      multi_axis = i[0];
      sosc_host_model_i.trig();
      wait_start();
      wait_done();
      chk(k[7:0], i[0] ? 8'h14 : 8'h0A);
    end
    multi_axis = 1'b0;
    n0 = starts;
    sosc_host_model_i.trig();
    wait_start();
    sosc_host_model_i.trig();
    sosc_host_model_i.trig();
    wait_done();
    wait_start();
    wait_done();
    repeat (30) @(negedge clock);
    chk(8'(starts - n0), 8'h02);
    sosc_host_model_i.wr(OFF_OP_TRIG, 8'h04);
    n0 = starts;
    sosc_host_model_i.trig();
    repeat (20) @(negedge clock);
    chk(8'(starts - n0), 8'h00);
    sosc_host_model_i.pin(1'b0);
    wait_start();
    chk(conv_start, 1'b1);
    sosc_host_model_i.pin(1'b1);
    wait_done();
    sosc_host_model_i.wr(OFF_OP_TRIG, 8'h01);
    chk(sleep_active, 1'b1);
    n0 = starts;
    sosc_host_model_i.trig();
    repeat (20) @(negedge clock);
    chk(8'(starts - n0), 8'h00);
    sosc_host_model_i.wr(OFF_OP_TRIG, 8'h02);
    n0 = starts;
    repeat (60) @(negedge clock);
    chk(starts - n0 >= 2, 1'b1);
    sosc_host_model_i.wr(OFF_OP_TRIG, 8'h00);
    repeat (30) @(negedge clock);
    sosc_host_model_i.wr(OFF_OP_TRIG, 8'h03);
    k = 0;
    while (idle_low_power !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    while (idle_low_power === 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    chk(k == 20 || k == 21, 1'b1);
    @(negedge clock);
    wake_exit = 1'b1;
    @(negedge clock);
    wake_exit = 1'b0;
    rdc(OFF_OP_TRIG, 8'h00);
    conclude();
  end
endmodule
bind sosc_config_bank sosc_config_bank_assertions
  sosc_config_bank_assertions_i (.*);
